// file: sat_counter.sv
`timescale 1ns/1ps
module sat_counter #(
    parameter int WIDTH = 28,
    parameter logic [WIDTH-1:0] MAX = '1
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic inc_i,
    input wire logic clr_i,
    output logic [WIDTH-1:0] count_o
);
    if (WIDTH < 2 || WIDTH > 64) begin : g_bad_width
        $error("sat_counter: WIDTH out of range");
    end

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic at_max;
    logic [WIDTH-1:0] one_w;

    assign one_w = {{(WIDTH-1){1'b0}}, 1'b1};
    assign at_max = (count_r == MAX);
    // A count arriving with the clear survives as one
    assign count_nxt = clr_i ? (inc_i ? one_w : '0) :
                       ((inc_i && !at_max) ? count_r + one_w : count_r);
    assign count_o = count_r;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    import tx_stats_pkg::*;

    `define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
        $display("[ERR] %s expected %h seen %h", nm, ex, gt); \
        err_count++; end end

    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic tx_byte_valid_i = 1'b0;
    logic [7:0] tx_byte_i = 8'h00;
    logic tx_sof_i = 1'b0;
    logic tx_end_i = 1'b0;
    logic tx_ok_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [REG_ADDR_W-1:0] rd_addr_i = 16'h0000;
    logic [REG_DATA_W-1:0] rd_data_o;
    logic rd_valid_o;
    int err_count = 0;
    int checks = 0;
    logic [31:0] exp_mix [7];

    always #2 core_clk_i = ~core_clk_i;

    tx_stats_counters dut (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .tx_byte_valid_i(tx_byte_valid_i),
        .tx_byte_i(tx_byte_i),
        .tx_sof_i(tx_sof_i),
        .tx_end_i(tx_end_i),
        .tx_ok_i(tx_ok_i),
        .rd_en_i(rd_en_i),
        .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One read; the answer stands for one cycle only, then data drops to 0
    task automatic rd(input logic [15:0] a, input logic [31:0] ex,
                      input string nm);
        @(posedge core_clk_i);
        #1;
        rd_en_i = 1'b1;
        rd_addr_i = a;
        @(posedge core_clk_i);
        #1;
        rd_en_i = 1'b0;
        rd_addr_i = ~a;
        `CHK("rd_valid", 1'b1, rd_valid_o)
        `CHK(nm, ex, rd_data_o)
        @(posedge core_clk_i);
        #1;
        `CHK("rd_idle_valid", 1'b0, rd_valid_o)
        `CHK("rd_idle_data", 32'h00000000, rd_data_o)
    endtask

    // Byte 0 is da0, bytes 1..4 da_mid, byte 5 da5, rest a running index
    task automatic send(input int len, input logic [7:0] da0,
                        input logic [7:0] da_mid, input logic [7:0] da5,
                        input logic ok);
        for (int i = 0; i < len; i++) begin
            @(posedge core_clk_i);
            #1;
            tx_byte_valid_i = 1'b1;
            tx_sof_i = (i == 0);
            tx_byte_i = (i == 0) ? da0 : (i < 5) ? da_mid :
                        (i == 5) ? da5 : i[7:0];
        end
        @(posedge core_clk_i);
        #1;
        tx_byte_valid_i = 1'b0;
        tx_sof_i = 1'b0;
        tx_byte_i = ~tx_byte_i;
        tx_end_i = 1'b1;
        tx_ok_i = ok;
        @(posedge core_clk_i);
        #1;
        tx_end_i = 1'b0;
        tx_ok_i = ~ok;
        // Frame counters settle two cycles after the end pulse
        repeat (3) @(posedge core_clk_i);
    endtask

    task automatic rd_all(input logic [31:0] e0, input logic [31:0] e1,
                          input logic [31:0] e2, input logic [31:0] e3,
                          input logic [31:0] e4, input logic [31:0] e5,
                          input logic [31:0] e6);
        exp_mix = '{e0, e1, e2, e3, e4, e5, e6};
        for (int a = 0; a < 7; a++) begin
            rd(TX_BYTE_COUNT_LOW_ADDR + a[15:0], exp_mix[a], "stat_reg");
        end
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge core_clk_i);
        $display("[ERR] watchdog expired");
        err_count++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge core_clk_i);
        #1;
        rst_n_i = 1'b1;

        rd_all(32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
        rd(16'h002F, 32'h00000000, "unmapped_low");
        rd(16'h0037, 32'h00000000, "unmapped_high");
        $display("test reset_and_unmapped done");

        // A padded minimum frame to the all-ones address
        send(64, 8'hFF, 8'hFF, 8'hFF, 1'b1);
        rd_all(32'h40, 32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0);
        rd_all(32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
        $display("test broadcast_64 done");

        // Size boundaries, near-broadcast and a failed frame
        send(65, 8'h01, 8'h00, 8'h00, 1'b1);
        send(127, 8'hFF, 8'hFF, 8'hFE, 1'b1);
        send(128, 8'h02, 8'h00, 8'h00, 1'b1);
        send(63, 8'h04, 8'h00, 8'h00, 1'b1);
        send(64, 8'hFF, 8'hFF, 8'hFF, 1'b0);
        rd_all(32'h1BF, 32'h0, 32'h4, 32'h0, 32'h2, 32'h0, 32'h2);
        $display("test size_classes done");

        // Unmapped reads between frames leave the counts alone
        send(100, 8'h00, 8'h00, 8'h00, 1'b1);
        rd(16'h0037, 32'h00000000, "unmapped_mid");
        rd(16'h0031, 32'h00000000, "high_alone");
        rd(TX_BYTE_COUNT_LOW_ADDR, 32'h00000064, "byte_low");
        rd(TX_BYTE_COUNT_HIGH_ADDR, 32'h00000000, "byte_high");
        rd(TX_FRAMES_OK_COUNT_ADDR, 32'h00000001, "frames_ok");
        rd(TX_LEN65_127_OK_COUNT_ADDR, 32'h00000001, "len65");
        rd(TX_FRAMES_OK_COUNT_ADDR, 32'h00000000, "frames_clr");
        $display("test unmapped_side_effect done");

        // A second reset in mid-run wipes every count
        send(64, 8'h01, 8'h00, 8'h00, 1'b1);
        #1;
        rst_n_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        rst_n_i = 1'b1;
        rd_all(32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
        $display("test mid_run_reset done");

        final_report();
    end
endmodule

// file: tx_frame_classifier.sv
`timescale 1ns/1ps
module tx_frame_classifier (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic sof_i,
    input wire logic end_i,
    input wire logic ok_i,
    output logic done_o,
    output logic bcast_o,
    output logic mcast_o,
    output logic len64_o,
    output logic len65_127_o
);
    import tx_stats_pkg::*;

    logic [LEN_W-1:0] len_r;
    logic [LEN_W-1:0] len_nxt;
    logic bcast_r;
    logic mcast_r;
    logic in_da;
    logic byte_ff;
    logic good_end;

    // ------------------------------------------------------------
    // Length and address tracking
    // ------------------------------------------------------------
    // length spans DA to FCS
    assign len_nxt = sof_i ? LEN_W'(1) :
                     ((len_r == LEN_MAX) ? len_r : len_r + LEN_W'(1));
    assign in_da = (len_r < DA_LEN);
    assign byte_ff = (byte_i == BCAST_BYTE);
    assign good_end = end_i && ok_i;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            len_r <= '0;
            bcast_r <= 1'b0;
            mcast_r <= 1'b0;
        end else if (byte_valid_i) begin
            len_r <= len_nxt;
            bcast_r <= sof_i ? byte_ff : (bcast_r && (!in_da || byte_ff));
            // first bit on wire is bit 0
            if (sof_i) begin
                mcast_r <= byte_i[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Result pulses at a successful frame end
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o <= 1'b0;
            bcast_o <= 1'b0;
            mcast_o <= 1'b0;
            len64_o <= 1'b0;
            len65_127_o <= 1'b0;
        end else begin
            done_o <= good_end;
            bcast_o <= good_end && bcast_r && (len_r >= DA_LEN);
            mcast_o <= good_end && mcast_r;
            len64_o <= good_end && (len_r == LEN_64);
            len65_127_o <= good_end && (len_r >= LEN_65) &&
                           (len_r <= LEN_127);
        end
    end
endmodule

// file: tx_stats_counters.sv
`timescale 1ns/1ps
// Behaviour
// - Every sent byte from the first destination byte to the FCS counts.
// - Pad bytes inserted by the MAC are counted as sent bytes.
// - The low byte word shows count bits 31 to 0 since it was last read.
// - The high byte-count word shows count bits 47 to 32, frozen at the last low read and cleared when it is read, in its low 16 bits.
// - Reading the low byte word restarts its accumulation from zero.
// - Every good frame is counted and frame counters stop at 0xFFFFFFF.
// - Reading the total, broadcast or multicast count returns and clears it.
// - Good frames sent to the all-ones address are counted as broadcast.
// - Good frames whose first address bit on the wire is one are multicast.
// - Good frames of exactly 64 bytes have their own counter.
// - Good frames of 65 to 127 bytes have their own counter.
// - Reading either size-class counter returns it then clears it.
module tx_stats_counters (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic tx_byte_valid_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_sof_i,
    input wire logic tx_end_i,
    input wire logic tx_ok_i,
    input wire logic rd_en_i,
    input wire logic [tx_stats_pkg::REG_ADDR_W-1:0] rd_addr_i,
    output logic [tx_stats_pkg::REG_DATA_W-1:0] rd_data_o,
    output logic rd_valid_o
);
    import tx_stats_pkg::*;

    logic cls_done;
    logic cls_bcast;
    logic cls_mcast;
    logic cls_len64;
    logic cls_len65;
    logic [NUM_FRAME_CNT-1:0] frame_inc;
    logic [NUM_FRAME_CNT-1:0] frame_clr;
    logic [FRAME_CNT_W-1:0] frame_cnt [NUM_FRAME_CNT];
    logic [BYTE_CNT_W-1:0] byte_cnt;
    logic [BYTE_HIGH_W-1:0] high_shadow_r;
    logic [BYTE_HIGH_W-1:0] high_shadow_nxt;
    logic rd_low;
    logic rd_high;
    logic [REG_DATA_W-1:0] rd_data_nxt;
    logic [REG_DATA_W-1:0] frame_word [NUM_FRAME_CNT];

    // ------------------------------------------------------------
    // Frame classification
    // ------------------------------------------------------------
    tx_frame_classifier u_cls (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .byte_valid_i(tx_byte_valid_i),
        .byte_i(tx_byte_i),
        .sof_i(tx_sof_i),
        .end_i(tx_end_i),
        .ok_i(tx_ok_i),
        .done_o(cls_done),
        .bcast_o(cls_bcast),
        .mcast_o(cls_mcast),
        .len64_o(cls_len64),
        .len65_127_o(cls_len65)
    );

    assign frame_inc[IDX_TOTAL] = cls_done;
    assign frame_inc[IDX_BCAST] = cls_bcast;
    assign frame_inc[IDX_MCAST] = cls_mcast;
    assign frame_inc[IDX_LEN64] = cls_len64;
    assign frame_inc[IDX_LEN65] = cls_len65;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    assign rd_low = rd_en_i && (rd_addr_i == TX_BYTE_COUNT_LOW_ADDR);
    assign rd_high = rd_en_i && (rd_addr_i == TX_BYTE_COUNT_HIGH_ADDR);
    assign frame_clr[IDX_TOTAL] = rd_en_i &&
        (rd_addr_i == TX_FRAMES_OK_COUNT_ADDR);
    assign frame_clr[IDX_BCAST] = rd_en_i &&
        (rd_addr_i == TX_BROADCAST_OK_COUNT_ADDR);
    assign frame_clr[IDX_MCAST] = rd_en_i &&
        (rd_addr_i == TX_MULTICAST_OK_COUNT_ADDR);
    assign frame_clr[IDX_LEN64] = rd_en_i &&
        (rd_addr_i == TX_LEN64_OK_COUNT_ADDR);
    assign frame_clr[IDX_LEN65] = rd_en_i &&
        (rd_addr_i == TX_LEN65_127_OK_COUNT_ADDR);

    // ------------------------------------------------------------
    // Frame counters
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FRAME_CNT; gi++) begin : g_frame
            sat_counter #(
                .WIDTH(FRAME_CNT_W),
                .MAX(FRAME_CNT_MAX)
            ) u_cnt (
                .core_clk_i(core_clk_i),
                .rst_n_i(rst_n_i),
                .inc_i(frame_inc[gi]),
                .clr_i(frame_clr[gi]),
                .count_o(frame_cnt[gi])
            );
            assign frame_word[gi] = {{(REG_DATA_W-FRAME_CNT_W){1'b0}},
                                     frame_cnt[gi]};
        end
    endgenerate

    // ------------------------------------------------------------
    // Byte counter
    // ------------------------------------------------------------
    // one count per sent byte
    // pad bytes arrive as ordinary valid bytes
    sat_counter #(
        .WIDTH(BYTE_CNT_W),
        .MAX(BYTE_CNT_MAX)
    ) u_bytes (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .inc_i(tx_byte_valid_i),
        .clr_i(rd_low),
        .count_o(byte_cnt)
    );

    // High half is frozen at the low read so both words form one count
    assign high_shadow_nxt = rd_low ? byte_cnt[BYTE_CNT_W-1:BYTE_LOW_W] :
                             (rd_high ? '0 : high_shadow_r);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            high_shadow_r <= '0;
        end else begin
            high_shadow_r <= high_shadow_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // low word bits 31..0
    // high word in low 16 bits
    assign rd_data_nxt =
        !rd_en_i ? RD_DATA_RESET :
        rd_low ? byte_cnt[BYTE_LOW_W-1:0] :
        rd_high ? {{(REG_DATA_W-BYTE_HIGH_W){1'b0}}, high_shadow_r} :
        frame_clr[IDX_TOTAL] ? frame_word[IDX_TOTAL] :
        frame_clr[IDX_BCAST] ? frame_word[IDX_BCAST] :
        frame_clr[IDX_MCAST] ? frame_word[IDX_MCAST] :
        frame_clr[IDX_LEN64] ? frame_word[IDX_LEN64] :
        frame_clr[IDX_LEN65] ? frame_word[IDX_LEN65] : RD_DATA_RESET;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= RD_DATA_RESET;
            rd_valid_o <= 1'b0;
        end else begin
            rd_data_o <= rd_data_nxt;
            rd_valid_o <= rd_en_i;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_read_latency: assert property (
        rd_valid_o == $past(rd_en_i) &&
            (rd_valid_o || rd_data_o == RD_DATA_RESET))
        else $error("read answer not one cycle after request");

    a_frames_cleared: assert property (
        frame_clr[IDX_TOTAL] && !cls_done |=>
            frame_cnt[IDX_TOTAL] == '0 &&
            rd_data_o == $past(frame_word[IDX_TOTAL]))
        else $error("total frame counter not returned and cleared");

    a_frames_saturate: assert property (
        frame_cnt[IDX_TOTAL] == FRAME_CNT_MAX && !frame_clr[IDX_TOTAL]
            |=> frame_cnt[IDX_TOTAL] == FRAME_CNT_MAX)
        else $error("frame counter left its maximum");

    a_bytes_count: assert property (
        tx_byte_valid_i && !rd_low && byte_cnt != BYTE_CNT_MAX
            |=> byte_cnt == $past(byte_cnt) + BYTE_CNT_W'(1))
        else $error("sent byte not counted");

    a_low_restart: assert property (
        rd_low |=> byte_cnt == BYTE_CNT_W'($past(tx_byte_valid_i)))
        else $error("byte count not restarted by low read");

    a_high_layout: assert property (
        rd_low ##1 (!rd_en_i)[*2] ##1 rd_high |=>
            rd_data_o[REG_DATA_W-1:BYTE_HIGH_W] == '0 &&
            rd_data_o[BYTE_HIGH_W-1:0] ==
            $past(byte_cnt[BYTE_CNT_W-1:BYTE_LOW_W], 4))
        else $error("high byte word does not match frozen bits");

    a_bcast_count: assert property (
        cls_bcast && !frame_clr[IDX_BCAST] &&
            frame_cnt[IDX_BCAST] != FRAME_CNT_MAX
            |=> frame_cnt[IDX_BCAST] ==
                $past(frame_cnt[IDX_BCAST]) + FRAME_CNT_W'(1))
        else $error("broadcast frame not counted");

    a_len64_cleared: assert property (
        frame_clr[IDX_LEN64] |=>
            frame_cnt[IDX_LEN64] == FRAME_CNT_W'($past(cls_len64)))
        else $error("64 byte class not cleared by read");

    a_class_implies_total: assert property (
        (cls_len64 || cls_len65 || cls_bcast || cls_mcast) |-> cls_done)
        else $error("class pulse without a good frame");

    // ------------------------------------------------------------
    // Counting checks
    // ------------------------------------------------------------
    a_total_count: assert property (
        cls_done && !frame_clr[IDX_TOTAL] &&
            frame_cnt[IDX_TOTAL] != FRAME_CNT_MAX
            |=> frame_cnt[IDX_TOTAL] ==
                $past(frame_cnt[IDX_TOTAL]) + FRAME_CNT_W'(1))
        else $error("good frame not counted");

    a_frames_hold: assert property (
        !cls_done && !frame_clr[IDX_TOTAL] |=>
            $stable(frame_cnt[IDX_TOTAL]))
        else $error("total frame counter moved without cause");

    a_mcast_count: assert property (
        cls_mcast && !frame_clr[IDX_MCAST] &&
            frame_cnt[IDX_MCAST] != FRAME_CNT_MAX
            |=> frame_cnt[IDX_MCAST] ==
                $past(frame_cnt[IDX_MCAST]) + FRAME_CNT_W'(1))
        else $error("multicast frame not counted");

    a_len64_count: assert property (
        cls_len64 && !frame_clr[IDX_LEN64] &&
            frame_cnt[IDX_LEN64] != FRAME_CNT_MAX
            |=> frame_cnt[IDX_LEN64] ==
                $past(frame_cnt[IDX_LEN64]) + FRAME_CNT_W'(1))
        else $error("64 byte frame not counted");

    a_len65_count: assert property (
        cls_len65 && !frame_clr[IDX_LEN65] &&
            frame_cnt[IDX_LEN65] != FRAME_CNT_MAX
            |=> frame_cnt[IDX_LEN65] ==
                $past(frame_cnt[IDX_LEN65]) + FRAME_CNT_W'(1))
        else $error("65 to 127 byte frame not counted");

    a_bytes_hold: assert property (
        !tx_byte_valid_i && !rd_low |=> $stable(byte_cnt))
        else $error("byte count moved without a byte");

    a_bytes_saturate: assert property (
        byte_cnt == BYTE_CNT_MAX && !rd_low |=> byte_cnt == BYTE_CNT_MAX)
        else $error("byte counter left its maximum");

    // ------------------------------------------------------------
    // Clearing checks
    // ------------------------------------------------------------
    a_low_read_data: assert property (
        rd_low |=> rd_data_o == $past(byte_cnt[BYTE_LOW_W-1:0]))
        else $error("low byte word not returned");

    a_bcast_cleared: assert property (
        frame_clr[IDX_BCAST] |=>
            frame_cnt[IDX_BCAST] == FRAME_CNT_W'($past(cls_bcast)))
        else $error("broadcast counter not cleared by read");

    a_bcast_read_data: assert property (
        frame_clr[IDX_BCAST] |=>
            rd_data_o == $past(frame_word[IDX_BCAST]))
        else $error("broadcast counter not returned");

    a_mcast_cleared: assert property (
        frame_clr[IDX_MCAST] |=>
            frame_cnt[IDX_MCAST] == FRAME_CNT_W'($past(cls_mcast)))
        else $error("multicast counter not cleared by read");

    a_mcast_read_data: assert property (
        frame_clr[IDX_MCAST] |=>
            rd_data_o == $past(frame_word[IDX_MCAST]))
        else $error("multicast counter not returned");

    a_len64_read_data: assert property (
        frame_clr[IDX_LEN64] |=>
            rd_data_o == $past(frame_word[IDX_LEN64]))
        else $error("64 byte class not returned");

    a_len65_cleared: assert property (
        frame_clr[IDX_LEN65] |=>
            frame_cnt[IDX_LEN65] == FRAME_CNT_W'($past(cls_len65)))
        else $error("65 to 127 byte class not cleared by read");

    a_len65_read_data: assert property (
        frame_clr[IDX_LEN65] |=>
            rd_data_o == $past(frame_word[IDX_LEN65]))
        else $error("65 to 127 byte class not returned");

    c_bcast_frame: cover property (cls_bcast && cls_len64);
    c_read_low_high: cover property (rd_low ##[1:4] rd_high);
    c_clear_and_count: cover property (frame_clr[IDX_TOTAL] && cls_done);
    c_mcast_mid: cover property (cls_mcast && cls_len65);
endmodule

// file: tx_stats_pkg.sv
package tx_stats_pkg;

    // ------------------------------------------------------------
    // Register space
    // ------------------------------------------------------------
    localparam int REG_ADDR_W = 16;
    localparam int REG_DATA_W = 32;
    localparam logic [15:0] TX_BYTE_COUNT_LOW_ADDR = 16'h0030;
    localparam logic [15:0] TX_BYTE_COUNT_HIGH_ADDR = 16'h0031;
    localparam logic [15:0] TX_FRAMES_OK_COUNT_ADDR = 16'h0032;
    localparam logic [15:0] TX_BROADCAST_OK_COUNT_ADDR = 16'h0033;
    localparam logic [15:0] TX_MULTICAST_OK_COUNT_ADDR = 16'h0034;
    localparam logic [15:0] TX_LEN64_OK_COUNT_ADDR = 16'h0035;
    localparam logic [15:0] TX_LEN65_127_OK_COUNT_ADDR = 16'h0036;

    // ------------------------------------------------------------
    // Counter layout and reset values
    // ------------------------------------------------------------
    localparam int BYTE_CNT_W = 48;
    localparam int BYTE_LOW_W = 32;
    localparam int BYTE_HIGH_W = 16;
    localparam int FRAME_CNT_W = 28;
    localparam logic [27:0] FRAME_CNT_MAX = 28'hFFFFFFF;
    localparam logic [47:0] BYTE_CNT_MAX = 48'hFFFFFFFFFFFF;
    localparam logic [47:0] BYTE_CNT_RESET = 48'h000000000000;
    localparam logic [27:0] FRAME_CNT_RESET = 28'h0000000;
    localparam logic [31:0] RD_DATA_RESET = 32'h00000000;
    localparam int NUM_FRAME_CNT = 5;
    localparam int IDX_TOTAL = 0;
    localparam int IDX_BCAST = 1;
    localparam int IDX_MCAST = 2;
    localparam int IDX_LEN64 = 3;
    localparam int IDX_LEN65 = 4;

    // ------------------------------------------------------------
    // Frame classification
    // ------------------------------------------------------------
    localparam int LEN_W = 16;
    localparam logic [15:0] LEN_MAX = 16'hFFFF;
    localparam logic [15:0] LEN_64 = 16'h0040;
    localparam logic [15:0] LEN_65 = 16'h0041;
    localparam logic [15:0] LEN_127 = 16'h007F;
    localparam logic [15:0] DA_LEN = 16'h0006;
    localparam logic [7:0] BCAST_BYTE = 8'hFF;

endpackage
